//--- src/rmac_defines.vh
// Notes on behaviour
// - Analog preset in target or NFC initiator modes clears transmitter enable.
// - In NFC mode the preset never turns the field on; field-on commands do.
// - NFC active preset sets start byte option: insert F0 start byte and length.
// - Preset sets peer field detect enable for NFC active, clears it otherwise.
// - Demodulator select from receive rate: peak detector for rates up to 848 kb/s.
// - Preset sets first/second stage clipping for NFC active, clears otherwise.
// - Preset sets forced gain reduction for NFC active, clears it otherwise.
// - Mask receive forces receive-active low and disables receive framing.
// - Effective receive mask is command mask OR mask-receive timer mask.
// - Unmask receive drives receive-active high and re-enables framing.
// - Unmask while mask timer runs enables reception at once and resets timer.
// - Mask and unmask are accepted only while receiver enable is set.
// - Mask and unmask may be chained and raise no completion interrupt.
// - Measure amplitude stores the receiver input amplitude in converter output.
// - While measuring: transmitter and detector on, detector to converter, absolute.
// - One result step equals 13.02 mVpp at the receiver inputs.
// - Amplitude measurement completes within 25 microseconds of the command.
// - Measure amplitude accepted only with global enable set and oscillator stable.
// - Measure amplitude is not chained; completion interrupt after it finishes.
// - Preset derives receiver and transmitter bits from mode and bit rate.
/*
 * Constants for the receive mask and amplitude command block: register
 * offsets, field positions, reset values, command codes and timing counts.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef RMAC_DEFINES_VH
`define RMAC_DEFINES_VH

// Register offsets
`define RMAC_OP_CTRL_ADDR      6'h02
`define RMAC_TYPEA_ADDR        6'h05
`define RMAC_AUX_DEF_ADDR      6'h09
`define RMAC_RX_CFG1_ADDR      6'h0a
`define RMAC_RX_CFG3_ADDR      6'h0c
`define RMAC_ADC_OUT_ADDR      6'h25

// Reset values
`define RMAC_OP_CTRL_RST       8'h00
`define RMAC_TYPEA_RST         8'h00
`define RMAC_AUX_DEF_RST       8'h00
`define RMAC_RX_CFG1_RST       8'h00
`define RMAC_RX_CFG3_RST       8'h00
`define RMAC_ADC_OUT_RST       8'h00

// Operation control fields
`define RMAC_OP_EN_BIT         7
`define RMAC_OP_RX_EN_BIT      6
`define RMAC_OP_RX_CHN_BIT     5
`define RMAC_OP_TX_EN_BIT      3
// Other preset fields
`define RMAC_TYPEA_F0_BIT      5
`define RMAC_AUX_TRAM_BIT      5
`define RMAC_AUX_FD_BIT        4
`define RMAC_RX1_CHSEL_BIT     7
`define RMAC_RX1_AMD_BIT       6
`define RMAC_RX3_LIM_BIT       1
`define RMAC_RX3_RG_BIT        0

// Mode definition layout: mode field in bits 6:3
`define RMAC_MODE_HI           6
`define RMAC_MODE_LO           3
`define RMAC_MODE_NFC_INI      4'h1
`define RMAC_MODE_NFC_TGT      4'h9
`define RMAC_MODE_TGT_BIT      3
// Bit rate definition: tx rate bits 5:4, rx rate bits 1:0
`define RMAC_TXR_HI            5
`define RMAC_TXR_LO            4
`define RMAC_RXR_HI            1
`define RMAC_RXR_LO            0
`define RMAC_RXR_MAX_PEAK      2'h3
`define RMAC_RATE_212          2'h1
`define RMAC_RATE_424          2'h2

// Direct command codes
`define RMAC_CMD_PRESET        8'hcc
`define RMAC_CMD_MASK          8'hd0
`define RMAC_CMD_UNMASK        8'hd1
`define RMAC_CMD_MEAS_AMP      8'hd3

// Timing: measurement limit 25 us is 3125 cycles at 125 MHz; last count index
`define RMAC_MEAS_LAST         12'hc34
`define RMAC_CNT_W             12

`endif

//--- src/rmac_sync.v
/*
 * Two flip-flop synchroniser for one level from outside the clock domain.
 * Assumes the input level is slow compared with the clock.
 */
`timescale 1ns/10ps
module rmac_sync (
    // Clock and reset
    input  wire mclk_i,
    input  wire reset_i,
    // Level
    input  wire async_i,
    output reg  sync_o
);
    reg meta;

    // First stage feeds only the second
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            meta   <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule // rmac_sync

//--- src/rmac_preset.v
/*
 * Combinational analog preset: new values of the preset registers from the
 * current register values, mode definition and bit rate definition.
 * Assumes the caller loads the results in one cycle.
 */
`timescale 1ns/10ps
`include "rmac_defines.vh"
module rmac_preset (
    // Current state
    input  wire [7:0] mode_def_i,
    input  wire [7:0] bit_rate_i,
    input  wire [7:0] op_ctrl_i,
    input  wire [7:0] typea_i,
    input  wire [7:0] aux_def_i,
    input  wire [7:0] rx_cfg1_i,
    input  wire [7:0] rx_cfg3_i,
    // Preset values
    output reg  [7:0] op_ctrl_o,
    output reg  [7:0] typea_o,
    output reg  [7:0] aux_def_o,
    output reg  [7:0] rx_cfg1_o,
    output reg  [7:0] rx_cfg3_o
);
    wire [3:0] mode    = mode_def_i[`RMAC_MODE_HI:`RMAC_MODE_LO];
    wire       nfc_act = (mode == `RMAC_MODE_NFC_INI) || (mode == `RMAC_MODE_NFC_TGT);
    wire       target  = mode_def_i[`RMAC_MODE_TGT_BIT];
    wire [1:0] txr     = bit_rate_i[`RMAC_TXR_HI:`RMAC_TXR_LO];
    wire [1:0] rxr     = bit_rate_i[`RMAC_RXR_HI:`RMAC_RXR_LO];

    // Preset bits from mode and bit rate
    always @* begin
        op_ctrl_o = op_ctrl_i;
        typea_o   = typea_i;
        aux_def_o = aux_def_i;
        rx_cfg1_o = rx_cfg1_i;
        rx_cfg3_o = rx_cfg3_i;
        // Transmitter only ever cleared here, never set
        if (target || nfc_act)
            op_ctrl_o[`RMAC_OP_TX_EN_BIT] = 1'b0;
        if (nfc_act) begin
            op_ctrl_o[`RMAC_OP_RX_CHN_BIT] = 1'b1;
            typea_o[`RMAC_TYPEA_F0_BIT]    = 1'b1;
            rx_cfg1_o[`RMAC_RX1_CHSEL_BIT] = 1'b0;
            aux_def_o[`RMAC_AUX_TRAM_BIT]  = (txr == `RMAC_RATE_212) || (txr == `RMAC_RATE_424);
        end
        aux_def_o[`RMAC_AUX_FD_BIT] = nfc_act;
        rx_cfg1_o[`RMAC_RX1_AMD_BIT] = (rxr > `RMAC_RXR_MAX_PEAK);
        rx_cfg3_o[`RMAC_RX3_LIM_BIT] = nfc_act;
        rx_cfg3_o[`RMAC_RX3_RG_BIT]  = nfc_act;
    end
endmodule // rmac_preset

//--- src/rmac_top.v
/*
 * Receive mask, unmask, analog preset and measure amplitude direct commands,
 * with the preset registers and the converter output register.
 * Assumes command and register strobes come from the host interface on
 * mclk_i, one cycle each; the converter and mask timer share the clock;
 * the oscillator stable flag is a pin and is synchronised here.
 */
`timescale 1ns/10ps
`include "rmac_defines.vh"
module rmac_top (
    // Clock and reset
    input  wire       mclk_i,
    input  wire       reset_i,
    // Register access
    input  wire       reg_wr_i,
    input  wire       reg_rd_i,
    input  wire [5:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    output reg  [7:0] reg_rdata_o,
    // Direct commands
    input  wire       cmd_valid_i,
    input  wire [7:0] cmd_code_i,
    output reg        cmd_done_irq_o,
    // Mode and bit rate definition
    input  wire [7:0] mode_def_i,
    input  wire [7:0] bit_rate_i,
    // Oscillator and mask timer
    input  wire       osc_stable_i,
    input  wire       mask_timer_active_i,
    output reg        mask_timer_reset_o,
    // Receiver
    output reg        rx_on_o,
    output reg        rx_framing_en_o,
    // Amplitude measurement path
    output reg        tx_drive_o,
    output reg        amp_det_en_o,
    output reg        adc_sel_amp_o,
    output reg        adc_abs_mode_o,
    output reg        adc_start_o,
    input  wire       adc_done_i,
    input  wire [7:0] adc_data_i,
    // Register contents
    output reg  [7:0] op_ctrl_o,
    output reg  [7:0] typea_o,
    output reg  [7:0] aux_def_o,
    output reg  [7:0] rx_cfg1_o,
    output reg  [7:0] rx_cfg3_o,
    output reg  [7:0] adc_out_o
);
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_MEAS = 2'b10;
    localparam [`RMAC_CNT_W-1:0] MEAS_LAST = `RMAC_MEAS_LAST;

    reg  [1:0]             state;
    reg  [1:0]             next_state;
    reg  [`RMAC_CNT_W-1:0] meas_cnt;
    reg                    cmd_mask;
    reg                    next_cmd_mask;
    reg                    meas_start;
    reg                    meas_end;
    wire                   osc_ok;
    wire [7:0]             pre_op;
    wire [7:0]             pre_typea;
    wire [7:0]             pre_aux;
    wire [7:0]             pre_rx1;
    wire [7:0]             pre_rx3;

    wire en_ok    = op_ctrl_o[`RMAC_OP_EN_BIT];
    wire rx_en    = op_ctrl_o[`RMAC_OP_RX_EN_BIT];
    wire idle     = (state == ST_IDLE);
    wire cmd_go   = cmd_valid_i && idle;
    wire do_pre   = cmd_go && (cmd_code_i == `RMAC_CMD_PRESET);
    wire do_mask  = cmd_go && (cmd_code_i == `RMAC_CMD_MASK) && rx_en;
    wire do_umask = cmd_go && (cmd_code_i == `RMAC_CMD_UNMASK) && rx_en;
    wire do_meas  = cmd_go && (cmd_code_i == `RMAC_CMD_MEAS_AMP)
                    && en_ok && osc_ok;
    wire wr_hit   = reg_wr_i && idle;
    // The timer obeys its reset one edge late, so its mask is ignored meanwhile
    wire tmr_mask = mask_timer_active_i && !mask_timer_reset_o;

    // Oscillator stable flag arrives from the analog side
    rmac_sync u_osc_sync (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .async_i (osc_stable_i),
        .sync_o  (osc_ok)
    );

    rmac_preset u_preset (
        .mode_def_i (mode_def_i),
        .bit_rate_i (bit_rate_i),
        .op_ctrl_i  (op_ctrl_o),
        .typea_i    (typea_o),
        .aux_def_i  (aux_def_o),
        .rx_cfg1_i  (rx_cfg1_o),
        .rx_cfg3_i  (rx_cfg3_o),
        .op_ctrl_o  (pre_op),
        .typea_o    (pre_typea),
        .aux_def_o  (pre_aux),
        .rx_cfg1_o  (pre_rx1),
        .rx_cfg3_o  (pre_rx3)
    );

    // Measurement sequencer; commands are refused while it runs
    always @* begin
        next_state = state;
        meas_start = 1'b0;
        meas_end   = 1'b0;
        case (state)
            ST_IDLE: begin
                if (do_meas) begin
                    next_state = ST_MEAS;
                    meas_start = 1'b1;
                end
            end
            ST_MEAS: begin
                // Timeout keeps the bound even if the converter never answers
                if (adc_done_i || (meas_cnt == MEAS_LAST)) begin
                    next_state = ST_IDLE;
                    meas_end   = 1'b1;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            state    <= ST_IDLE;
            meas_cnt <= {`RMAC_CNT_W{1'b0}};
        end else begin
            state <= next_state;
            if (meas_start)
                meas_cnt <= {`RMAC_CNT_W{1'b0}};
            else if (state == ST_MEAS)
                meas_cnt <= meas_cnt + 1'b1;
        end
    end

    // Command mask: set by mask, cleared by unmask
    always @* begin
        next_cmd_mask = cmd_mask;
        if (do_mask)
            next_cmd_mask = 1'b1;
        else if (do_umask)
            next_cmd_mask = 1'b0;
    end

    // Receiver gating; unmask also overrides a running timer at once
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            cmd_mask           <= 1'b0;
            rx_on_o            <= 1'b0;
            rx_framing_en_o    <= 1'b0;
            mask_timer_reset_o <= 1'b0;
        end else begin
            cmd_mask           <= next_cmd_mask;
            mask_timer_reset_o <= do_umask && mask_timer_active_i;
            if (do_umask) begin
                rx_on_o         <= rx_en;
                rx_framing_en_o <= rx_en;
            end else begin
                // Either mask source holds the receiver off
                rx_on_o         <= rx_en && !(next_cmd_mask || tmr_mask);
                rx_framing_en_o <= rx_en && !(next_cmd_mask || tmr_mask);
            end
        end
    end

    // Analog path during measurement, absolute converter mode
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_drive_o     <= 1'b0;
            amp_det_en_o   <= 1'b0;
            adc_sel_amp_o  <= 1'b0;
            adc_abs_mode_o <= 1'b0;
            adc_start_o    <= 1'b0;
        end else begin
            tx_drive_o     <= (next_state == ST_MEAS) || op_ctrl_o[`RMAC_OP_TX_EN_BIT];
            amp_det_en_o   <= (next_state == ST_MEAS);
            adc_sel_amp_o  <= (next_state == ST_MEAS);
            adc_abs_mode_o <= (next_state == ST_MEAS);
            adc_start_o    <= meas_start;
        end
    end

    // Completion pulse only for measurement, never for mask commands
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i)
            cmd_done_irq_o <= 1'b0;
        else
            cmd_done_irq_o <= meas_end;
    end

    // Register file: host writes, preset loads, converter result
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            op_ctrl_o <= `RMAC_OP_CTRL_RST;
            typea_o   <= `RMAC_TYPEA_RST;
            aux_def_o <= `RMAC_AUX_DEF_RST;
            rx_cfg1_o <= `RMAC_RX_CFG1_RST;
            rx_cfg3_o <= `RMAC_RX_CFG3_RST;
            adc_out_o <= `RMAC_ADC_OUT_RST;
        end else begin
            if (do_pre) begin
                op_ctrl_o <= pre_op;
                typea_o   <= pre_typea;
                aux_def_o <= pre_aux;
                rx_cfg1_o <= pre_rx1;
                rx_cfg3_o <= pre_rx3;
            end else if (wr_hit) begin
                case (reg_addr_i)
                    `RMAC_OP_CTRL_ADDR: op_ctrl_o <= reg_wdata_i;
                    `RMAC_TYPEA_ADDR:   typea_o   <= reg_wdata_i;
                    `RMAC_AUX_DEF_ADDR: aux_def_o <= reg_wdata_i;
                    `RMAC_RX_CFG1_ADDR: rx_cfg1_o <= reg_wdata_i;
                    `RMAC_RX_CFG3_ADDR: rx_cfg3_o <= reg_wdata_i;
                    default:            op_ctrl_o <= op_ctrl_o;
                endcase
            end
            // Raw code, one step is 13.02 mVpp at the inputs
            if (meas_end)
                adc_out_o <= adc_data_i;
        end
    end

    // Read data registered one cycle after the strobe; unmapped reads zero
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i) begin
            case (reg_addr_i)
                `RMAC_OP_CTRL_ADDR: reg_rdata_o <= op_ctrl_o;
                `RMAC_TYPEA_ADDR:   reg_rdata_o <= typea_o;
                `RMAC_AUX_DEF_ADDR: reg_rdata_o <= aux_def_o;
                `RMAC_RX_CFG1_ADDR: reg_rdata_o <= rx_cfg1_o;
                `RMAC_RX_CFG3_ADDR: reg_rdata_o <= rx_cfg3_o;
                `RMAC_ADC_OUT_ADDR: reg_rdata_o <= adc_out_o;
                default:            reg_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule // rmac_top

//--- test/rmac_props.sv
/*
 * Checker for the receive mask and amplitude command block.
 * Assumes it is bound to rmac_top and sees only that module's ports.
 */
`timescale 1ns/10ps
module rmac_props (
    // Clock and reset
    input wire       mclk_i,
    input wire       reset_i,
    // Commands
    input wire       cmd_valid_i,
    input wire [7:0] cmd_code_i,
    input wire       cmd_done_irq_o,
    input wire [7:0] mode_def_i,
    // Timer and receiver
    input wire       mask_timer_active_i,
    input wire       mask_timer_reset_o,
    input wire       rx_on_o,
    input wire       rx_framing_en_o,
    // Measurement path
    input wire       tx_drive_o,
    input wire       amp_det_en_o,
    input wire       adc_sel_amp_o,
    input wire       adc_abs_mode_o,
    input wire       adc_start_o,
    // Registers
    input wire [7:0] op_ctrl_o,
    input wire [7:0] aux_def_o,
    input wire [7:0] rx_cfg3_o
);
    localparam int MEAS_MAX = 3125;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // Command taken only while no measurement runs
    wire acc = cmd_valid_i && !amp_det_en_o;
    wire nfc = (mode_def_i[6:3] == 4'h1) || (mode_def_i[6:3] == 4'h9);
    reg [11:0] meas_cnt;
    // Length of the measuring window, so the bound needs no huge delay range
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) meas_cnt <= 12'h000;
        else meas_cnt <= amp_det_en_o ? meas_cnt + 12'h001 : 12'h000;
    end
    sequence s_meas_start;
        adc_start_o && adc_sel_amp_o && adc_abs_mode_o && tx_drive_o ##1 !adc_start_o;
    endsequence
    sequence s_done;
        cmd_done_irq_o ##1 !cmd_done_irq_o;
    endsequence
    a_mask_forces_off: assert property (acc && cmd_code_i == 8'hd0 && op_ctrl_o[6]
        |=> !rx_on_o && !rx_framing_en_o) else $error("mask left receiver on");
    a_unmask_turns_on: assert property (acc && cmd_code_i == 8'hd1 && op_ctrl_o[6]
        |=> rx_on_o && rx_framing_en_o) else $error("unmask left receiver off");
    a_timer_masks_rx: assert property ($rose(mask_timer_active_i) |=> !rx_on_o)
        else $error("timer did not mask");
    a_timer_reset_pulse: assert property (mask_timer_reset_o |-> rx_on_o ##1
        !mask_timer_reset_o) else $error("timer reset wrong");
    a_no_irq_chain: assert property (acc && cmd_code_i inside {8'hd0, 8'hd1, 8'hcc}
        |=> !cmd_done_irq_o) else $error("irq on chainable command");
    a_meas_enables: assert property ($rose(amp_det_en_o) |-> s_meas_start)
        else $error("measure path not set");
    a_meas_refused: assert property (acc && cmd_code_i == 8'hd3 && !op_ctrl_o[7]
        |=> !amp_det_en_o) else $error("measure run without enable");
    a_meas_bound: assert property (meas_cnt <= MEAS_MAX)
        else $error("measure too long");
    a_irq_at_end: assert property ($fell(amp_det_en_o) |-> s_done)
        else $error("no completion irq");
    a_irq_cause: assert property (cmd_done_irq_o |-> $past(amp_det_en_o))
        else $error("stray irq");
    a_preset_nfc: assert property (acc && cmd_code_i == 8'hcc && nfc |=>
        !op_ctrl_o[3] && aux_def_o[4] && rx_cfg3_o[1:0] == 2'h3) else $error("nfc preset");
endmodule // rmac_props
bind rmac_top rmac_props u_props (.mclk_i(mclk_i), .reset_i(reset_i),
    .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_done_irq_o(cmd_done_irq_o),
    .mode_def_i(mode_def_i), .mask_timer_active_i(mask_timer_active_i),
    .mask_timer_reset_o(mask_timer_reset_o), .rx_on_o(rx_on_o),
    .rx_framing_en_o(rx_framing_en_o), .tx_drive_o(tx_drive_o), .amp_det_en_o(amp_det_en_o),
    .adc_sel_amp_o(adc_sel_amp_o), .adc_abs_mode_o(adc_abs_mode_o),
    .adc_start_o(adc_start_o), .op_ctrl_o(op_ctrl_o), .aux_def_o(aux_def_o),
    .rx_cfg3_o(rx_cfg3_o));

//--- test/rmac_host.sv
/*
 * Host model: register and direct command strobes, one cycle each.
 * Assumes the bench calls its tasks one at a time after reset.
 */
`timescale 1ns/10ps
module rmac_host (
    // Clock and read data
    input wire        mclk_i,
    input wire [7:0]  reg_rdata_o,
    // Strobes towards the block
    output reg        reg_wr_i,
    output reg        reg_rd_i,
    output reg  [5:0] reg_addr_i,
    output reg  [7:0] reg_wdata_i,
    output reg        cmd_valid_i,
    output reg  [7:0] cmd_code_i
);
    initial begin
        {reg_wr_i, reg_rd_i, cmd_valid_i} = 3'h0;
        reg_addr_i = 6'h00;
        reg_wdata_i = 8'h00;
        cmd_code_i = 8'h00;
    end
    // Write: taken at the edge that ends the pulse
    task wr(input [5:0] a, input [7:0] d);
        @(posedge mclk_i) begin reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d; end
        @(posedge mclk_i) reg_wr_i <= 1'b0;
    endtask
    // Read: data is registered at the read edge and then holds
    task rd(input [5:0] a, output [7:0] d);
        @(posedge mclk_i) begin reg_rd_i <= 1'b1; reg_addr_i <= a; end
        @(posedge mclk_i) reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    // Chainable and single commands both use this; measure waits are the bench's job
    task cmd(input [7:0] c);
        @(posedge mclk_i) begin cmd_valid_i <= 1'b1; cmd_code_i <= c; end
        @(posedge mclk_i) cmd_valid_i <= 1'b0;
    endtask
endmodule // rmac_host

//--- test/tb.sv
/*
 * Self-checking bench for rmac_top: register access, presets, receive
 * masking and amplitude measurement. Assumes the host model drives strobes.
 */
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb;
    reg        mclk_i = 1'b0;
    reg        reset_i = 1'b1;
    reg  [7:0] mode_def_i = 8'h00;
    reg  [7:0] bit_rate_i = 8'h11;
    reg        osc_stable_i = 1'b0;
    reg        mask_timer_active_i = 1'b0;
    reg        adc_done_i = 1'b0;
    reg  [7:0] adc_data_i = 8'h00;
    wire       reg_wr_i, reg_rd_i, cmd_valid_i, cmd_done_irq_o, mask_timer_reset_o;
    wire       rx_on_o, rx_framing_en_o, tx_drive_o, amp_det_en_o, adc_sel_amp_o;
    wire       adc_abs_mode_o, adc_start_o;
    wire [5:0] reg_addr_i;
    wire [7:0] reg_wdata_i, reg_rdata_o, cmd_code_i, op_ctrl_o, typea_o, aux_def_o;
    wire [7:0] rx_cfg1_o, rx_cfg3_o, adc_out_o;
    int        n_errors = 0;
    int        check_count = 0;
    logic [7:0] rd;
    logic       nfc;
    // Mode and bit rate pairs also toggle the fields the preset ignores
    logic [7:0] modes [3] = '{8'h8a, 8'h4d, 8'h97};
    logic [7:0] rates [3] = '{8'he6, 8'h3c, 8'hd1};
    logic [5:0] addrs [5] = '{6'h02, 6'h05, 6'h09, 6'h0a, 6'h0c};
    always #4 mclk_i = ~mclk_i;
    rmac_host u_host (.mclk_i(mclk_i), .reg_rdata_o(reg_rdata_o), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i));
    rmac_top uut (.mclk_i(mclk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
        .cmd_done_irq_o(cmd_done_irq_o), .mode_def_i(mode_def_i), .bit_rate_i(bit_rate_i),
        .osc_stable_i(osc_stable_i), .mask_timer_active_i(mask_timer_active_i),
        .mask_timer_reset_o(mask_timer_reset_o), .rx_on_o(rx_on_o),
        .rx_framing_en_o(rx_framing_en_o), .tx_drive_o(tx_drive_o),
        .amp_det_en_o(amp_det_en_o), .adc_sel_amp_o(adc_sel_amp_o),
        .adc_abs_mode_o(adc_abs_mode_o), .adc_start_o(adc_start_o), .adc_done_i(adc_done_i),
        .adc_data_i(adc_data_i), .op_ctrl_o(op_ctrl_o), .typea_o(typea_o),
        .aux_def_o(aux_def_o), .rx_cfg1_o(rx_cfg1_o), .rx_cfg3_o(rx_cfg3_o),
        .adc_out_o(adc_out_o));
    // Let n edges land, then look just after the last one
    task step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Whole run is a little over 3125 cycles, most of it the timeout measurement; this margin only catches a hang
    initial begin
        repeat (5000) @(posedge mclk_i);
        n_errors++;
        wrap_up;
    end
    initial begin
        repeat (10) @(posedge mclk_i);
        reset_i <= 1'b0;
        // Register map, read-only and unmapped places
        u_host.rd(6'h02, rd); `CHK(rd, 8'h00);
        for (int i = 0; i < 5; i++) begin
            u_host.wr(addrs[i], 8'h5a);
            u_host.rd(addrs[i], rd); `CHK(rd, 8'h5a);
            u_host.wr(addrs[i], 8'h00);
        end
        u_host.wr(6'h25, 8'hff);
        u_host.rd(6'h25, rd); `CHK(rd, 8'h00);
        u_host.rd(6'h3f, rd); `CHK(rd, 8'h00);
        $display("test regs done");
        // Preset over NFC initiator, NFC target and a reader mode
        for (int i = 0; i < 3; i++) begin
            nfc = (i < 2);
            @(posedge mclk_i) begin mode_def_i <= modes[i]; bit_rate_i <= rates[i]; end
            u_host.wr(6'h02, 8'hc8);
            u_host.cmd(8'hcc); step(1);
            `CHK(op_ctrl_o[3], ~nfc);
            `CHK(typea_o[5], 1'b1);
            `CHK(aux_def_o[4], nfc);
            `CHK(rx_cfg1_o[6], 1'b0);
            `CHK(rx_cfg3_o[1], nfc);
            `CHK(rx_cfg3_o[0], nfc);
            if (nfc) `CHK(aux_def_o[5], i == 0);
        end
        $display("test preset done");
        // Masking by command, refusal without receiver enable, timer masking
        u_host.wr(6'h02, 8'hc0);
        u_host.cmd(8'hd1); step(1); `CHK(rx_on_o, 1'b1);
        `CHK(rx_framing_en_o, 1'b1);
        u_host.cmd(8'hd0); step(1); `CHK(rx_on_o, 1'b0);
        `CHK(rx_framing_en_o, 1'b0);
        u_host.wr(6'h02, 8'h80);
        u_host.cmd(8'hd1);
        u_host.wr(6'h02, 8'hc0); step(2); `CHK(rx_on_o, 1'b0);
        u_host.cmd(8'hd1); step(1); `CHK(rx_on_o, 1'b1);
        @(posedge mclk_i) mask_timer_active_i <= 1'b1;
        step(2); `CHK(rx_on_o, 1'b0);
        // Reset pulse stands one cycle; the timer model obeys it at the next edge
        u_host.cmd(8'hd1); #1 `CHK(rx_on_o, 1'b1);
        `CHK(mask_timer_reset_o, 1'b1);
        @(posedge mclk_i) mask_timer_active_i <= 1'b0;
        #1 `CHK(mask_timer_reset_o, 1'b0);
        `CHK(rx_on_o, 1'b1);
        `CHK(cmd_done_irq_o, 1'b0);
        $display("test mask done");
        // Measure refused: oscillator not stable, then global enable clear
        u_host.cmd(8'hd3); step(2); `CHK(amp_det_en_o, 1'b0);
        @(posedge mclk_i) osc_stable_i <= 1'b1;
        u_host.wr(6'h02, 8'h40); step(3);
        u_host.cmd(8'hd3); step(2); `CHK(amp_det_en_o, 1'b0);
        `CHK(adc_out_o, 8'h00);
        // Measure accepted, write during it ignored, converter result e6 stored
        u_host.wr(6'h02, 8'hc0);
        u_host.cmd(8'hf3); step(1); `CHK(amp_det_en_o, 1'b0);
        u_host.cmd(8'hd3); #1;
        `CHK({amp_det_en_o, adc_sel_amp_o, adc_abs_mode_o, tx_drive_o}, 4'hf);
        `CHK(adc_start_o, 1'b1);
        u_host.wr(6'h02, 8'h00);
        @(posedge mclk_i) begin adc_done_i <= 1'b1; adc_data_i <= 8'he6; end
        @(posedge mclk_i) adc_done_i <= 1'b0;
        #1 `CHK(cmd_done_irq_o, 1'b1);
        `CHK(adc_out_o, 8'he6);
        `CHK(amp_det_en_o, 1'b0);
        step(1); `CHK(cmd_done_irq_o, 1'b0);
        u_host.rd(6'h02, rd); `CHK(rd, 8'hc0);
        u_host.rd(6'h25, rd); `CHK(rd, 8'he6);
        // No converter answer: the block must give up in time by itself
        @(posedge mclk_i) adc_data_i <= 8'h19;
        u_host.cmd(8'hd3);
        for (int i = 0; i < 3125 && cmd_done_irq_o !== 1'b1; i++) step(1);
        `CHK(cmd_done_irq_o, 1'b1);
        `CHK(adc_out_o, 8'h19);
        $display("test measure done");
        wrap_up;
    end
endmodule // tb
